// [logic/tccat_top.v]
// type-c attach timing: cc debounce, drp toggle, vconn, recovery, dcd/bc
// assumes comparator inputs already synchronous to core_clk
`timescale 1ns/1ns
`default_nettype none
`include "tccat_defs.vh"
// Functional notes
// - cc change accepted after 100-200 ms stable
// - pull-down attached within 15 ms of clamp removal
// - error recovery held at least 25 ms
// - drp toggle period 50 to 100 ms
// - each role 30-70 percent of period
// - role switch completes within 1 ms
// - vconn on within 2 ms of vbus
// - vconn off within 35 ms detach/command
// - sink current updated within 60 ms
// - vbus on within 275 ms reference
// - vbus safe within 650 ms reference
// - current limit 0-4.0A, 33.3mA steps
// - current limit resets to 100-500mA default
// - charge only with input in window
// - dcd prebias, line change starts identification
// - dcd times out after 700-900 ms
// - bc state times out 180-220 ms
module tccat_top #(
  parameter TICK_CYC = `TCCAT_TICK_CYC
) (
  input wire core_clk,
  input wire rst,
  input wire drp_en, // dual-role toggling enabled
  input wire cc_partner_seen, // comparator: partner termination present
  input wire [1:0] cc_adv_level, // sink-side advertised current level
  input wire vbus_present, // vbus valid comparator
  input wire vbus_safe0v, // vbus below safe level
  input wire clamp_removed, // dead-battery clamp released
  input wire vconn_off_cmd, // host command pulse
  input wire [`TCCAT_ILIM_W-1:0] ilim_wr_data, // new current limit code
  input wire ilim_wr, // write strobe for current limit
  input wire charger_input_below_ovlo, // charger_input below input_overvoltage_lockout_level
  input wire charger_input_above_uvlo, // above input_undervoltage_level
  input wire charger_input_above_sys, // above input_to_system_threshold
  input wire dp_state, // data line comparators
  input wire dn_state,
  input wire bc_result, // detection produced a result
  input wire err_event, // request for error recovery
  output reg role_source, // advertised role, 1 = source
  output reg rd_connect, // sink pull-down attached
  output reg vconn_en, // vconn switch closed
  output reg vbus_src_en, // drive vbus as source
  output reg [1:0] sink_cur_level, // applied sink current level
  output reg [`TCCAT_ILIM_W-1:0] input_current_limit_setting,
  output reg charge_en, // charging allowed
  output reg dcd_prebias, // prebias data lines
  output reg identify_start, // one-cycle pulse, start port identification
  output reg dcd_timeout, // pulse
  output reg bc_timeout, // pulse
  output wire [2:0] port_state // current port state
);
  // ==========================================
  // shared millisecond tick
  reg [15:0] tdiv_q; // divider
  reg tick_q; // one-cycle tick
  always @(posedge core_clk) begin
    if (rst) begin
      tdiv_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (tdiv_q == TICK_CYC[15:0] - 16'h0001) begin
      tdiv_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      tdiv_q <= tdiv_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end
  // ==========================================
  // cc debounce: restart on any change of the raw sample
  reg cc_last_q; // previous raw value
  reg cc_deb_q; // debounced attach
  reg deb_load; // restart debounce timer
  wire deb_exp; // debounce interval elapsed
  always @* begin
    deb_load = (cc_partner_seen != cc_last_q);
  end
  tccat_timer #(.W(10)) u_deb (
    .core_clk(core_clk), .rst(rst), .tick(tick_q), .load(deb_load),
    .load_val(10'd`TCCAT_CC_DEB_MS), .expired(deb_exp)
  );
  always @(posedge core_clk) begin
    if (rst) begin
      cc_last_q <= 1'b0;
      cc_deb_q <= 1'b0;
    end else begin
      cc_last_q <= cc_partner_seen;
      if (deb_exp && !deb_load)
        cc_deb_q <= cc_last_q;
    end
  end
  // ==========================================
  // port state machine with a single state timer
  reg [2:0] st_q; // port state
  reg st_load; // restart state timer
  reg [9:0] st_val; // value to load
  wire st_exp;
  reg [2:0] st_d;
  reg [1:0] adv_last_q; // last seen advertised level
  reg vcoff_pend_q; // vconn removal pending
  reg st_load_arm_q; // arms the toggle timer once after reset or when drp_en rises while unattached
  assign port_state = st_q;
  tccat_timer #(.W(10)) u_st (
    .core_clk(core_clk), .rst(rst), .tick(tick_q), .load(st_load),
    .load_val(st_val), .expired(st_exp)
  );
  // next state and timer reload
  always @* begin
    st_d = st_q;
    st_load = 1'b0;
    st_val = 10'd0;
    case (st_q)
      `TCCAT_ST_UNATT: begin
        if (err_event) begin
          st_d = `TCCAT_ST_ERR_REC;
          st_load = 1'b1;
          st_val = 10'd`TCCAT_ERR_REC_USE_MS;
        end else if (cc_deb_q && role_source) begin
          st_d = drp_en ? `TCCAT_ST_DRP_WAIT : `TCCAT_ST_ATT_SRC;
        end else if (cc_deb_q) begin
          st_d = `TCCAT_ST_ATT_SNK;
          st_load = 1'b1;
          st_val = 10'd`TCCAT_RD_DELAY_MS;
        end else if (drp_en && st_exp) begin
          // alternate halves of the toggle period
          st_load = 1'b1;
          st_val = role_source ? 10'd`TCCAT_DRP_SRC_MS : 10'd`TCCAT_DRP_SRC_MS;
        end else if (drp_en && !st_exp && !st_load_arm_q) begin
          st_load = 1'b1;
          st_val = 10'd`TCCAT_DRP_SRC_MS;
        end
      end
      `TCCAT_ST_DRP_WAIT, `TCCAT_ST_ATT_SRC: begin
        if (err_event) begin
          st_d = `TCCAT_ST_ERR_REC;
          st_load = 1'b1;
          st_val = 10'd`TCCAT_ERR_REC_USE_MS;
        end else if (!cc_deb_q) begin
          st_d = `TCCAT_ST_UNATT;
        end
      end
      `TCCAT_ST_ATT_SNK: begin
        if (err_event) begin
          st_d = `TCCAT_ST_ERR_REC;
          st_load = 1'b1;
          st_val = 10'd`TCCAT_ERR_REC_USE_MS;
        end else if (!cc_deb_q) begin
          st_d = `TCCAT_ST_UNATT;
        end
      end
      `TCCAT_ST_ERR_REC: begin
        if (st_exp)
          st_d = `TCCAT_ST_UNATT;
      end
      default: st_d = `TCCAT_ST_UNATT;
    endcase
  end
  // state, role and port outputs
  always @(posedge core_clk) begin
    if (rst) begin
      st_q <= `TCCAT_ST_UNATT;
      st_load_arm_q <= 1'b0;
      role_source <= 1'b0;
      rd_connect <= 1'b0;
      vconn_en <= 1'b0;
      vbus_src_en <= 1'b0;
      sink_cur_level <= 2'b00;
      adv_last_q <= 2'b00;
      vcoff_pend_q <= 1'b0;
    end else begin
      st_q <= st_d;
      st_load_arm_q <= (st_d == `TCCAT_ST_UNATT) && drp_en;
      // role flips in one cycle at the half-period boundary
      if (st_q == `TCCAT_ST_UNATT && drp_en && st_exp && !cc_deb_q)
        role_source <= ~role_source;
      else if (!drp_en && st_q == `TCCAT_ST_UNATT)
        role_source <= 1'b0;
      // pull-down follows clamp removal immediately when sinking
      rd_connect <= clamp_removed && !role_source;
      // vbus sourcing applied on the same edge that enters source attach or dual-role wait
      vbus_src_en <= (st_d == `TCCAT_ST_ATT_SRC) || (st_d == `TCCAT_ST_DRP_WAIT);
      // vconn closes as soon as vbus is seen in dual-role wait
      if (st_q == `TCCAT_ST_DRP_WAIT && vbus_present && !vcoff_pend_q)
        vconn_en <= 1'b1;
      // detach or host command opens vconn on the next edge
      if (vconn_off_cmd || st_d == `TCCAT_ST_UNATT || st_d == `TCCAT_ST_ERR_REC) begin
        vconn_en <= 1'b0;
        vcoff_pend_q <= vconn_off_cmd;
      end else if (st_d != `TCCAT_ST_DRP_WAIT) begin
        vcoff_pend_q <= 1'b0;
      end
      // sink current tracks the advertised level within two cycles
      adv_last_q <= cc_adv_level;
      if (st_q == `TCCAT_ST_ATT_SNK)
        sink_cur_level <= adv_last_q;
      else
        sink_cur_level <= 2'b00;
    end
  end
  // ==========================================
  // input current limit and charge enable
  always @(posedge core_clk) begin
    if (rst) begin
      input_current_limit_setting <= `TCCAT_ILIM_RST;
      charge_en <= 1'b0;
    end else begin
      if (ilim_wr)
        input_current_limit_setting <= (ilim_wr_data > `TCCAT_ILIM_MAX) ?
          `TCCAT_ILIM_MAX : ilim_wr_data;
      charge_en <= charger_input_below_ovlo && charger_input_above_uvlo && charger_input_above_sys;
    end
  end
  // ==========================================
  // data contact detection and charger detection timeouts
  reg [1:0] dt_q; // detection state
  reg [1:0] dl_last_q; // previous data-line sample
  reg [9:0] dt_cnt_q; // ms counter for detection
  always @(posedge core_clk) begin
    if (rst) begin
      dt_q <= `TCCAT_DT_IDLE;
      dl_last_q <= 2'b00;
      dt_cnt_q <= 10'd0;
      dcd_prebias <= 1'b0;
      identify_start <= 1'b0;
      dcd_timeout <= 1'b0;
      bc_timeout <= 1'b0;
    end else begin
      identify_start <= 1'b0;
      dcd_timeout <= 1'b0;
      bc_timeout <= 1'b0;
      dl_last_q <= {dp_state, dn_state};
      if (tick_q)
        dt_cnt_q <= dt_cnt_q + 10'd1;
      case (dt_q)
        `TCCAT_DT_IDLE: begin
          if (vbus_present && st_q == `TCCAT_ST_ATT_SNK) begin
            dt_q <= `TCCAT_DT_DCD;
            dcd_prebias <= 1'b1;
            dt_cnt_q <= 10'd0;
          end
        end
        `TCCAT_DT_DCD: begin
          if ({dp_state, dn_state} != dl_last_q) begin
            dt_q <= `TCCAT_DT_BC;
            dcd_prebias <= 1'b0;
            identify_start <= 1'b1;
            dt_cnt_q <= 10'd0;
          end else if (dt_cnt_q >= 10'd`TCCAT_DCD_TMO_MS) begin
            dt_q <= `TCCAT_DT_BC;
            dcd_prebias <= 1'b0;
            dcd_timeout <= 1'b1;
            identify_start <= 1'b1;
            dt_cnt_q <= 10'd0;
          end
        end
        `TCCAT_DT_BC: begin
          if (bc_result) begin
            dt_q <= `TCCAT_DT_DONE;
          end else if (dt_cnt_q >= 10'd`TCCAT_BC_TMO_MS) begin
            dt_q <= `TCCAT_DT_DONE;
            bc_timeout <= 1'b1;
          end
        end
        `TCCAT_DT_DONE: begin
          if (!vbus_present)
            dt_q <= `TCCAT_DT_IDLE;
        end
        default: dt_q <= `TCCAT_DT_IDLE;
      endcase
    end
  end
endmodule // tccat_top
`default_nettype wire

// [include/tccat_defs.vh]
// timing constants and encodings for the type-c attach timing block
// assumes a 25 MHz core clock and a 1 ms tick derived from it
`ifndef TCCAT_DEFS_VH
`define TCCAT_DEFS_VH
// ==========================================
// clock and tick
`define TCCAT_CLK_KHZ 25000
`define TCCAT_TICK_CYC (`TCCAT_CLK_KHZ * 1)
// ==========================================
// intervals in milliseconds (ticks)
`define TCCAT_CC_DEB_MIN_MS 100
`define TCCAT_CC_DEB_MS 150
`define TCCAT_CLAMP_SWAP_MS 15
`define TCCAT_RD_DELAY_MS 2
`define TCCAT_ERR_REC_MS 25
`define TCCAT_ERR_REC_USE_MS 26
`define TCCAT_DRP_PERIOD_MS 76
`define TCCAT_DRP_SRC_MS 38
`define TCCAT_DRP_TRANS_MS 1
`define TCCAT_VCONN_ON_MS 2
`define TCCAT_VCONN_OFF_MS 35
`define TCCAT_SINK_ADJ_MS 60
`define TCCAT_VBUS_ON_MS 275
`define TCCAT_VBUS_OFF_MS 650
`define TCCAT_DCD_TMO_MS 800
`define TCCAT_BC_TMO_MS 200
// ==========================================
// input current limit, codes of 33.3 mA, 0 to 4.0 A
`define TCCAT_ILIM_W 7
`define TCCAT_ILIM_MAX 7'h78
`define TCCAT_ILIM_RST 7'h0F
// ==========================================
// port states
`define TCCAT_ST_UNATT 3'h0
`define TCCAT_ST_ATT_SRC 3'h1
`define TCCAT_ST_ATT_SNK 3'h2
`define TCCAT_ST_ERR_REC 3'h3
`define TCCAT_ST_DRP_WAIT 3'h4
// detection states
`define TCCAT_DT_IDLE 2'h0
`define TCCAT_DT_DCD 2'h1
`define TCCAT_DT_BC 2'h2
`define TCCAT_DT_DONE 2'h3
`endif

// [logic/tccat_timer.v]
// down-counting interval timer advanced by the shared millisecond tick
// assumes tick is a one-cycle pulse from the parent
`timescale 1ns/1ns
`default_nettype none
module tccat_timer #(
  parameter W = 10
) (
  input wire core_clk,
  input wire rst,
  input wire tick,
  input wire load,
  input wire [W-1:0] load_val,
  output wire expired
);
  reg [W-1:0] cnt_q; // ticks remaining
  reg run_q; // timer armed
  // ==========================================
  // counter: load restarts, tick counts down
  always @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= {W{1'b0}};
      run_q <= 1'b0;
    end else if (load) begin
      cnt_q <= load_val;
      run_q <= 1'b1;
    end else if (run_q && tick && cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end
  assign expired = run_q && (cnt_q == {W{1'b0}});
endmodule // tccat_timer
`default_nettype wire

// [testbench/tccat_sva.sv]
// checker for tccat_top: one-cycle answers and interval floors/ceilings
// assumes one core_clk domain with synchronous active-high rst
`timescale 1ns/1ns
`default_nettype none
`include "tccat_defs.vh"
module tccat_sva #(
  parameter TICK_CYC = 25000
) (
  input wire core_clk,
  input wire rst,
  input wire drp_en,
  input wire cc_partner_seen,
  input wire vconn_off_cmd,
  input wire [6:0] ilim_wr_data,
  input wire ilim_wr,
  input wire charger_input_below_ovlo,
  input wire charger_input_above_uvlo,
  input wire charger_input_above_sys,
  input wire role_source,
  input wire vconn_en,
  input wire [6:0] input_current_limit_setting,
  input wire charge_en,
  input wire dcd_prebias,
  input wire identify_start,
  input wire [2:0] port_state
);
  // ==========================================
  // helper counters
  reg role_q; // last advertised role
  reg cc_q; // last raw partner level
  reg [31:0] run_q, stab_q, err_q, det_q; // run, stable, recovery, detach
  wire unatt = port_state == `TCCAT_ST_UNATT;
  wire err = port_state == `TCCAT_ST_ERR_REC;
  wire win = charger_input_below_ovlo && charger_input_above_uvlo && charger_input_above_sys;
  // counters restart on any change of what they watch
  always @(posedge core_clk) begin
    if (rst) begin
      // counters cleared and last values sampled in reset so no unknown survives into the counts
      role_q <= role_source;
      cc_q <= cc_partner_seen;
      run_q <= 32'h0;
      stab_q <= 32'h0;
      err_q <= 32'h0;
      det_q <= 32'h0;
    end else begin
      role_q <= role_source;
      cc_q <= cc_partner_seen;
      run_q <= (!unatt || !drp_en || role_source != role_q) ? 32'h0 : run_q + 32'h1;
      stab_q <= (cc_partner_seen != cc_q) ? 32'h0 : stab_q + 32'h1;
      err_q <= err ? err_q + 32'h1 : 32'h0;
      det_q <= (vconn_en && unatt) ? det_q + 32'h1 : 32'h0;
    end
  end
  // ==========================================
  // assertions
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (rst);
  ilim_update_a: assert property (ilim_wr |=> input_current_limit_setting ==
    ($past(ilim_wr_data) > 7'h78 ? 7'h78 : $past(ilim_wr_data)))
    else $error("current limit not updated");
  reset_vals_a: assert property ($past(rst) |-> unatt && !vconn_en &&
    input_current_limit_setting == `TCCAT_ILIM_RST) else $error("bad reset values");
  charge_win_a: assert property (!$past(rst) |-> charge_en == $past(win))
    else $error("charge enable outside window");
  vconn_cmd_a: assert property (vconn_off_cmd |=> !vconn_en)
    else $error("vconn kept after off command");
  vconn_detach_a: assert property (det_q <= 35 * TICK_CYC)
    else $error("vconn kept after detach");
  ident_pulse_a: assert property (identify_start |-> $past(dcd_prebias) ##1 !identify_start)
    else $error("identify pulse wrong");
  role_run_a: assert property (run_q <= 70 * TICK_CYC)
    else $error("role held too long");
  deb_min_a: assert property (!$past(rst) && $past(unatt) && !unatt && !err |->
    stab_q >= 100 * TICK_CYC) else $error("attach accepted early");
  err_hold_a: assert property (!$past(rst) && $past(err) && !err |->
    err_q >= 25 * TICK_CYC) else $error("recovery left early");
  ilim_c: cover property (ilim_wr);
  err_c: cover property (err);
  attach_c: cover property ($past(unatt) && !unatt && !err);
  role_c: cover property ($fell(role_source));
endmodule // tccat_sva
bind tccat_top tccat_sva #(.TICK_CYC(TICK_CYC)) u_sva (
  .core_clk(core_clk), .rst(rst), .drp_en(drp_en), .cc_partner_seen(cc_partner_seen),
  .vconn_off_cmd(vconn_off_cmd), .ilim_wr_data(ilim_wr_data), .ilim_wr(ilim_wr),
  .charger_input_below_ovlo(charger_input_below_ovlo), .charger_input_above_uvlo(charger_input_above_uvlo),
  .charger_input_above_sys(charger_input_above_sys), .role_source(role_source), .vconn_en(vconn_en),
  .input_current_limit_setting(input_current_limit_setting), .charge_en(charge_en),
  .dcd_prebias(dcd_prebias), .identify_start(identify_start), .port_state(port_state));
`default_nettype wire

// [testbench/tccat_partner.sv]
// port partner model: cc termination, vbus, data pin contact
// assumes attach and data_ok come from the bench
`timescale 1ns/1ns
`default_nettype none
module tccat_partner (
  input wire logic core_clk,
  input wire logic attach, // partner plugged in
  input wire logic data_ok, // data pins make contact
  input wire logic role_source, // device role, 1 = source
  input wire logic vbus_src_en, // device drives vbus
  input wire logic dcd_prebias, // device prebiases data lines
  output var logic cc_partner_seen = 1'b0,
  output var logic vbus_present = 1'b0,
  output var logic dp_state = 1'b0,
  output var logic dn_state = 1'b0
);
  // a sink partner needs device vbus, a source supplies its own
  always @(posedge core_clk) begin
    cc_partner_seen <= attach;
    vbus_present <= attach && (role_source ? vbus_src_en : 1'b1);
    dp_state <= attach && data_ok && dcd_prebias;
    dn_state <= 1'b0;
  end
endmodule // tccat_partner
`default_nettype wire

// [testbench/tb_typec_cc_attach_timing.sv]
// bench for tccat_top with a partner model; one tick is 10 cycles
// assumes the checker is bound to the design
`timescale 1ns/1ns
`default_nettype none
`include "tccat_defs.vh"
module tb_typec_cc_attach_timing;
  // ==========================================
  // signals, all inputs valued at time zero
  logic core_clk = 0, rst = 1, drp_en = 1, att = 0, vconn_off_cmd = 0;
  logic ilim_wr = 0, ovlo = 0, uvlo = 0, sys = 0, err_event = 0;
  logic dok = 1, clamp = 1; // partner data contact, clamp released
  logic [6:0] ilim_wr_data = 0, ilim;
  logic cc, vbus, dp, dn, role, rd, vconn, vsrc, chg, pre, idst, dto, bto;
  logic [1:0] lvl, adv = 2'h1;
  logic [2:0] st;
  int n_mismatch = 0, n_compared = 0, cyc = 0, k;
  initial forever #20 core_clk = ~core_clk;
  tccat_top #(.TICK_CYC(10)) DUT (.core_clk(core_clk), .rst(rst), .drp_en(drp_en),
    .cc_partner_seen(cc), .cc_adv_level(adv), .vbus_present(vbus), .vbus_safe0v(1'b0),
    .clamp_removed(clamp), .vconn_off_cmd(vconn_off_cmd), .ilim_wr_data(ilim_wr_data),
    .ilim_wr(ilim_wr), .charger_input_below_ovlo(ovlo), .charger_input_above_uvlo(uvlo),
    .charger_input_above_sys(sys), .dp_state(dp), .dn_state(dn), .bc_result(1'b0),
    .err_event(err_event), .role_source(role), .rd_connect(rd), .vconn_en(vconn),
    .vbus_src_en(vsrc), .sink_cur_level(lvl), .input_current_limit_setting(ilim),
    .charge_en(chg), .dcd_prebias(pre), .identify_start(idst), .dcd_timeout(dto),
    .bc_timeout(bto), .port_state(st));
  tccat_partner u_partner (.core_clk(core_clk), .attach(att), .data_ok(dok),
    .role_source(role), .vbus_src_en(vsrc), .dcd_prebias(pre), .cc_partner_seen(cc),
    .vbus_present(vbus), .dp_state(dp), .dn_state(dn));
  // ==========================================
  // helpers
  task w(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task t_reset;
    rst <= 1'b1;
    w(5);
    rst <= 1'b0;
    w(1);
    chk("state", `TCCAT_ST_UNATT, st);
    chk("vconn", 0, vconn);
    chk("ilim", `TCCAT_ILIM_RST, ilim);
  endtask
  task t_ilim;
    logic [6:0] c[4] = '{7'h00, 7'h78, 7'h79, 7'h7F};
    foreach (c[i]) begin
      ilim_wr <= 1'b1;
      ilim_wr_data <= c[i];
      w(1);
      ilim_wr <= 1'b0;
      w(1);
      chk("ilim", c[i] > 7'h78 ? 7'h78 : c[i], ilim);
    end
  endtask
  task t_charge;
    for (int i = 0; i < 8; i++) begin
      {ovlo, uvlo, sys} <= i[2:0];
      w(2);
      chk("charge_en", i == 7, chg);
    end
  endtask
  task t_toggle;
    int hi, lo;
    hi = 0;
    lo = 0;
    k = 0;
    while (role !== 1'b0 && k < 2000) begin w(1); k++; end
    while (role !== 1'b1 && k < 2000) begin w(1); k++; end
    while (role === 1'b1 && hi < 2000) begin w(1); hi++; end
    while (role === 1'b0 && lo < 2000) begin w(1); lo++; end
    chk("period ok", 1, hi + lo >= 500 && hi + lo <= 1000);
    chk("duty ok", 1, hi * 10 >= 3 * (hi + lo) && hi * 10 <= 7 * (hi + lo));
  endtask
  task t_attach;
    att <= 1'b1;
    w(500);
    att <= 1'b0;
    w(20);
    att <= 1'b1;
    w(990);
    chk("state early", `TCCAT_ST_UNATT, st);
    k = 0;
    while (st === `TCCAT_ST_UNATT && k < 1100) begin w(1); k++; end
    chk("attached", 1, st !== `TCCAT_ST_UNATT);
    w(3);
    chk("vconn on", st === `TCCAT_ST_DRP_WAIT, vconn);
    vconn_off_cmd <= 1'b1;
    w(1);
    vconn_off_cmd <= 1'b0;
    w(1);
    chk("vconn off", 0, vconn);
  endtask
  task t_err;
    err_event <= 1'b1;
    w(1);
    err_event <= 1'b0;
    k = 0;
    while (st !== `TCCAT_ST_ERR_REC && k < 5) begin w(1); k++; end
    w(245);
    chk("still recovering", `TCCAT_ST_ERR_REC, st);
    k = 0;
    while (st === `TCCAT_ST_ERR_REC && k < 1000) begin w(1); k++; end
    chk("left recovery", 1, st !== `TCCAT_ST_ERR_REC);
  endtask
  // sink attach: pull-down, prebias, identification, current level, bc timeout
  task t_sink;
    drp_en <= 1'b0;
    clamp <= 1'b0;
    adv <= 2'h2;
    dok <= 1'b1;
    w(3);
    chk("rd before clamp", 0, rd);
    clamp <= 1'b1;
    w(2);
    chk("rd after clamp", 1, rd);
    att <= 1'b1;
    k = 0;
    while (st === `TCCAT_ST_UNATT && k < 2000) begin w(1); k++; end
    chk("sink state", `TCCAT_ST_ATT_SNK, st);
    w(1);
    chk("prebias", 1, pre);
    k = 0;
    while (idst !== 1'b1 && k < 20) begin w(1); k++; end
    chk("identify", 1, idst);
    chk("sink level", 2'h2, lvl);
    adv <= 2'h3;
    w(3);
    chk("sink level new", 2'h3, lvl);
    k = 0;
    while (bto !== 1'b1 && k < 2300) begin w(1); k++; end
    chk("bc timeout ms", 1, bto === 1'b1 && k >= 1780 && k <= 2200);
  endtask
  // detach, then attach without data contact: dcd must time out
  task t_dcd;
    att <= 1'b0;
    k = 0;
    while (st !== `TCCAT_ST_UNATT && k < 2000) begin w(1); k++; end
    chk("detached", `TCCAT_ST_UNATT, st);
    w(2);
    chk("sink level idle", 0, lvl);
    dok <= 1'b0;
    att <= 1'b1;
    k = 0;
    while (st === `TCCAT_ST_UNATT && k < 2000) begin w(1); k++; end
    k = 0;
    while (dto !== 1'b1 && k < 9500) begin w(1); k++; end
    chk("dcd timeout ms", 1, dto === 1'b1 && k >= 7000 && k <= 9000);
  endtask
  // ==========================================
  // main sequence and cycle ceiling
  initial begin
    t_reset();
    t_ilim();
    t_charge();
    t_toggle();
    t_attach();
    t_reset();
    att <= 1'b0;
    t_err();
    t_sink();
    t_dcd();
    end_sim();
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      end_sim();
    end
  end
endmodule // tb_typec_cc_attach_timing
`default_nettype wire
